// *** rtl/aco_defs.vh ***
// register offsets, field positions and reset values of the channel one config bank
`ifndef ACO_DEFS_VH
`define ACO_DEFS_VH

`define ACO_OFS_INPUT_SETUP 8'h3c
`define ACO_OFS_GAIN 8'h3d
`define ACO_OFS_VOLUME 8'h3e
`define ACO_OFS_TRIM 8'h3f
`define ACO_OFS_PHASE 8'h40

`define ACO_RST_INPUT_SETUP 8'h00
`define ACO_RST_GAIN 8'h00
`define ACO_RST_VOLUME 8'hc9
`define ACO_RST_TRIM 8'h80
`define ACO_RST_PHASE 8'h00

`define ACO_MASK_INPUT_SETUP 8'hfd
`define ACO_MASK_TRIM 8'hf0

`define ACO_BIT_KIND 7
`define ACO_SRC_HI 6
`define ACO_SRC_LO 5
`define ACO_BIT_COUPLING 4
`define ACO_IMP_HI 3
`define ACO_IMP_LO 2
`define ACO_BIT_ENHANCE 0
`define ACO_GAIN_HI 7
`define ACO_GAIN_LO 1
`define ACO_BIT_NEG 0
`define ACO_GCAL_HI 7
`define ACO_GCAL_LO 4

`define ACO_SRC_DIFF 2'h0
`define ACO_SRC_SINGLE 2'h1
`define ACO_SRC_PULSE 2'h2
`define ACO_IMP_2K5 2'h0
`define ACO_IMP_10K 2'h1
`define ACO_IMP_20K 2'h2
`define ACO_GAIN_MAX 7'h54
`define ACO_VOL_ZERO 8'hc9
`define ACO_GCAL_ZERO 4'h8

`endif

// *** rtl/aco_regs.v ***
// channel one configuration registers with decoded control outputs
`timescale 1ns/10ps
`include "aco_defs.vh"

module aco_regs (
	input wire mclk_i,
	input wire reset_n_i,
	input wire clk_en_i,
	input wire wr_en_i,
	input wire [7:0] addr_i,
	input wire [7:0] wdata_i,
	output reg [7:0] rdata_o,
	output reg ch_a_input_kind_o,
	output reg [1:0] ch_a_input_source_o,
	output reg ch_a_pulse_mic_sel_o,
	output reg ch_a_coupling_select_o,
	output reg ch_a_dc_coupled_o,
	output reg [1:0] ch_a_impedance_select_o,
	output reg ch_a_range_enhance_on_o,
	output reg [6:0] ch_a_gain_code_o,
	output reg ch_a_gain_negative_o,
	output reg [8:0] ch_a_gain_half_db_o,
	output reg ch_a_gain_invalid_o,
	output reg [7:0] ch_a_volume_code_o,
	output reg ch_a_mute_o,
	output reg signed [9:0] ch_a_volume_half_db_o,
	output reg [3:0] ch_a_gain_trim_o,
	output reg signed [4:0] ch_a_trim_tenth_db_o,
	output reg [7:0] ch_a_phase_trim_o
);

	reg [7:0] input_setup;
	reg [7:0] gain;
	reg [7:0] volume;
	reg [7:0] trim;
	reg [7:0] phase;
	reg [7:0] next_rdata;
	reg next_invalid;
	reg next_pulse_mic_sel;
	reg next_dc_coupled;
	reg next_mute;
	reg [8:0] next_gain_half_db;
	reg signed [9:0] next_volume_half_db;
	reg signed [4:0] next_trim_tenth_db;
	wire [1:0] src;
	wire [1:0] imp;
	wire [6:0] gcode;
	wire [3:0] gcal;
	wire analog_src;

	assign src = input_setup[`ACO_SRC_HI:`ACO_SRC_LO];
	assign imp = input_setup[`ACO_IMP_HI:`ACO_IMP_LO];
	assign gcode = gain[`ACO_GAIN_HI:`ACO_GAIN_LO];
	assign gcal = trim[`ACO_GCAL_HI:`ACO_GCAL_LO];
	assign analog_src = (src == `ACO_SRC_DIFF) || (src == `ACO_SRC_SINGLE);

	// ----------------------------------------
	// configuration registers
	// ----------------------------------------
	// one process per register so a write can only ever touch its own byte
	always @(posedge mclk_i)
	begin
		if (!reset_n_i)
		begin
			input_setup <= `ACO_RST_INPUT_SETUP;
		end
		else if (clk_en_i && wr_en_i && addr_i == `ACO_OFS_INPUT_SETUP)
		begin
			input_setup <= wdata_i & `ACO_MASK_INPUT_SETUP;
		end
	end

	always @(posedge mclk_i)
	begin
		if (!reset_n_i)
		begin
			gain <= `ACO_RST_GAIN;
		end
		else if (clk_en_i && wr_en_i && addr_i == `ACO_OFS_GAIN)
		begin
			gain <= wdata_i;
		end
	end

	always @(posedge mclk_i)
	begin
		if (!reset_n_i)
		begin
			volume <= `ACO_RST_VOLUME;
		end
		else if (clk_en_i && wr_en_i && addr_i == `ACO_OFS_VOLUME)
		begin
			volume <= wdata_i;
		end
	end

	// low nibble is reserved and forced to zero on the way in
	always @(posedge mclk_i)
	begin
		if (!reset_n_i)
		begin
			trim <= `ACO_RST_TRIM;
		end
		else if (clk_en_i && wr_en_i && addr_i == `ACO_OFS_TRIM)
		begin
			trim <= wdata_i & `ACO_MASK_TRIM;
		end
	end

	always @(posedge mclk_i)
	begin
		if (!reset_n_i)
		begin
			phase <= `ACO_RST_PHASE;
		end
		else if (clk_en_i && wr_en_i && addr_i == `ACO_OFS_PHASE)
		begin
			phase <= wdata_i;
		end
	end

	// ----------------------------------------
	// read decode
	// ----------------------------------------
	// unmapped addresses read as zero
	always @*
	begin
		next_rdata = 8'h00;
		if (addr_i == `ACO_OFS_INPUT_SETUP)
			next_rdata = input_setup;
		else if (addr_i == `ACO_OFS_GAIN)
			next_rdata = gain;
		else if (addr_i == `ACO_OFS_VOLUME)
			next_rdata = volume;
		else if (addr_i == `ACO_OFS_TRIM)
			next_rdata = trim;
		else if (addr_i == `ACO_OFS_PHASE)
			next_rdata = phase;
	end

	// ----------------------------------------
	// reserved and unsupported settings
	// ----------------------------------------
	// reserved codes are stored as written; this flag only reports them
	always @*
	begin
		next_invalid = 1'b0;
		if (gcode > `ACO_GAIN_MAX)
			next_invalid = 1'b1;
		if (gain[`ACO_BIT_NEG] && imp == `ACO_IMP_2K5)
			next_invalid = 1'b1;
		if (src == 2'h3 || imp == 2'h3)
			next_invalid = 1'b1;
	end

	// ----------------------------------------
	// decoded values ahead of the output flops
	// ----------------------------------------
	always @*
	begin
		// pins themselves are muxed elsewhere once software sets them up
		next_pulse_mic_sel = (src == `ACO_SRC_PULSE);
		next_dc_coupled = 1'b0;
		// coupling only matters on an analog source
		if (analog_src)
			next_dc_coupled = input_setup[`ACO_BIT_COUPLING];
		next_mute = (volume == 8'h00);
		next_gain_half_db = {2'b00, gcode};
		// half dB units relative to the 0 dB volume code
		next_volume_half_db = $signed({2'b00, volume}) - $signed({2'b00, `ACO_VOL_ZERO});
		next_trim_tenth_db = $signed({1'b0, gcal}) - $signed({1'b0, `ACO_GCAL_ZERO});
	end

	// ----------------------------------------
	// output flops: read data
	// ----------------------------------------
	always @(posedge mclk_i)
	begin
		if (!reset_n_i)
		begin
			rdata_o <= 8'h00;
		end
		else if (clk_en_i)
		begin
			rdata_o <= next_rdata;
		end
	end

	// ----------------------------------------
	// output flops: input path
	// ----------------------------------------
	always @(posedge mclk_i)
	begin
		if (!reset_n_i)
		begin
			ch_a_input_kind_o <= 1'b0;
			ch_a_input_source_o <= `ACO_SRC_DIFF;
			ch_a_pulse_mic_sel_o <= 1'b0;
			ch_a_coupling_select_o <= 1'b0;
			ch_a_dc_coupled_o <= 1'b0;
			ch_a_impedance_select_o <= `ACO_IMP_2K5;
			ch_a_range_enhance_on_o <= 1'b0;
		end
		else if (clk_en_i)
		begin
			ch_a_input_kind_o <= input_setup[`ACO_BIT_KIND];
			ch_a_input_source_o <= src;
			ch_a_pulse_mic_sel_o <= next_pulse_mic_sel;
			ch_a_coupling_select_o <= input_setup[`ACO_BIT_COUPLING];
			ch_a_dc_coupled_o <= next_dc_coupled;
			ch_a_impedance_select_o <= imp;
			// the enhancer, gain and compressor choice is made outside
			ch_a_range_enhance_on_o <= input_setup[`ACO_BIT_ENHANCE];
		end
	end

	// ----------------------------------------
	// output flops: analog gain
	// ----------------------------------------
	// the invalid flag is advisory; the raw code still goes out
	always @(posedge mclk_i)
	begin
		if (!reset_n_i)
		begin
			ch_a_gain_code_o <= 7'h00;
			ch_a_gain_negative_o <= 1'b0;
			ch_a_gain_half_db_o <= 9'h000;
			ch_a_gain_invalid_o <= 1'b0;
		end
		else if (clk_en_i)
		begin
			ch_a_gain_code_o <= gcode;
			ch_a_gain_negative_o <= gain[`ACO_BIT_NEG];
			ch_a_gain_half_db_o <= next_gain_half_db;
			ch_a_gain_invalid_o <= next_invalid;
		end
	end

	// ----------------------------------------
	// output flops: digital volume
	// ----------------------------------------
	always @(posedge mclk_i)
	begin
		if (!reset_n_i)
		begin
			ch_a_volume_code_o <= `ACO_VOL_ZERO;
			ch_a_mute_o <= 1'b0;
			ch_a_volume_half_db_o <= 10'sh000;
		end
		else if (clk_en_i)
		begin
			ch_a_volume_code_o <= volume;
			ch_a_mute_o <= next_mute;
			ch_a_volume_half_db_o <= next_volume_half_db;
		end
	end

	// ----------------------------------------
	// output flops: gain trim
	// ----------------------------------------
	always @(posedge mclk_i)
	begin
		if (!reset_n_i)
		begin
			ch_a_gain_trim_o <= `ACO_GCAL_ZERO;
			ch_a_trim_tenth_db_o <= 5'sh00;
		end
		else if (clk_en_i)
		begin
			ch_a_gain_trim_o <= gcal;
			ch_a_trim_tenth_db_o <= next_trim_tenth_db;
		end
	end

	// ----------------------------------------
	// output flops: phase trim
	// ----------------------------------------
	// the delay line itself sits in the modulator path, not here
	always @(posedge mclk_i)
	begin
		if (!reset_n_i)
		begin
			ch_a_phase_trim_o <= 8'h00;
		end
		else if (clk_en_i)
		begin
			ch_a_phase_trim_o <= phase;
		end
	end

endmodule

// *** bench/aco_regs_asserts.sv ***
// checker for the channel one config bank outputs
`timescale 1ns/10ps
module aco_regs_asserts (
	input wire mclk_i, reset_n_i, clk_en_i, wr_en_i,
	input wire [7:0] addr_i, wdata_i, rdata_o, ch_a_phase_trim_o,
	input wire ch_a_input_kind_o, ch_a_coupling_select_o, ch_a_dc_coupled_o,
	input wire ch_a_pulse_mic_sel_o, ch_a_range_enhance_on_o,
	input wire [1:0] ch_a_input_source_o, ch_a_impedance_select_o,
	input wire [8:0] ch_a_gain_half_db_o,
	input wire signed [9:0] ch_a_volume_half_db_o,
	input wire signed [4:0] ch_a_trim_tenth_db_o
);
default clocking @(posedge mclk_i); endclocking
default disable iff (!reset_n_i);
// ----------------
// properties
// ----------------
// decode flops need one more enabled edge after the write
sequence s_w(logic [7:0] x); clk_en_i && wr_en_i && addr_i == x ##1 clk_en_i; endsequence
property p_setup; s_w(8'h3c) |=> {ch_a_input_kind_o, ch_a_input_source_o, ch_a_coupling_select_o,
	ch_a_impedance_select_o, 1'h0, ch_a_range_enhance_on_o} == ($past(wdata_i, 2) & 8'hfd); endproperty
a_setup: assert property (p_setup) else $error("setup fields wrong");
property p_gain; s_w(8'h3d) |=> ch_a_gain_half_db_o == ($past(wdata_i, 2) >> 1); endproperty
a_gain: assert property (p_gain) else $error("gain decode wrong");
property p_vol; s_w(8'h3e) |=> ch_a_volume_half_db_o == $past(wdata_i, 2) - 10'h0c9; endproperty
a_vol: assert property (p_vol) else $error("volume decode wrong");
property p_trim; s_w(8'h3f) |=> ch_a_trim_tenth_db_o == 5'($past(wdata_i, 2) >> 4) - 5'h08; endproperty
a_trim: assert property (p_trim) else $error("trim decode wrong");
property p_phase; s_w(8'h40) |=> ch_a_phase_trim_o == $past(wdata_i, 2); endproperty
a_phase: assert property (p_phase) else $error("phase trim wrong");
property p_pulse; ch_a_pulse_mic_sel_o == (ch_a_input_source_o == 2'h2); endproperty
a_pulse: assert property (p_pulse) else $error("pulse select wrong");
property p_dc; ch_a_dc_coupled_o == (ch_a_coupling_select_o && !ch_a_input_source_o[1]); endproperty
a_dc: assert property (p_dc) else $error("coupling gate wrong");
property p_rsv; clk_en_i && addr_i == 8'h3c |=> !rdata_o[1]; endproperty
a_rsv: assert property (p_rsv) else $error("reserved bit reads one");
endmodule
bind aco_regs aco_regs_asserts aco_regs_asserts_inst (
	.mclk_i(mclk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i), .wr_en_i(wr_en_i),
	.addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
	.ch_a_phase_trim_o(ch_a_phase_trim_o), .ch_a_input_kind_o(ch_a_input_kind_o),
	.ch_a_coupling_select_o(ch_a_coupling_select_o), .ch_a_dc_coupled_o(ch_a_dc_coupled_o),
	.ch_a_pulse_mic_sel_o(ch_a_pulse_mic_sel_o),
	.ch_a_range_enhance_on_o(ch_a_range_enhance_on_o),
	.ch_a_input_source_o(ch_a_input_source_o),
	.ch_a_impedance_select_o(ch_a_impedance_select_o),
	.ch_a_gain_half_db_o(ch_a_gain_half_db_o),
	.ch_a_volume_half_db_o(ch_a_volume_half_db_o),
	.ch_a_trim_tenth_db_o(ch_a_trim_tenth_db_o)
);

// *** bench/tb_aco_regs.sv ***
// self-checking bench for the channel one config bank
`timescale 1ns/10ps
module tb_aco_regs;
reg mclk_i = 0, reset_n_i = 0, clk_en_i = 1, wr_en_i = 0;
reg [7:0] addr_i = 8'h00, wdata_i = 8'h00;
wire [7:0] rdata_o, ch_a_volume_code_o, ch_a_phase_trim_o;
wire [1:0] ch_a_input_source_o, ch_a_impedance_select_o;
wire [6:0] ch_a_gain_code_o;
wire [8:0] ch_a_gain_half_db_o;
wire [3:0] ch_a_gain_trim_o;
wire signed [9:0] ch_a_volume_half_db_o;
wire signed [4:0] ch_a_trim_tenth_db_o;
wire ch_a_input_kind_o, ch_a_pulse_mic_sel_o, ch_a_coupling_select_o, ch_a_dc_coupled_o;
wire ch_a_range_enhance_on_o, ch_a_gain_negative_o, ch_a_gain_invalid_o, ch_a_mute_o;
integer errors = 0, checked = 0;
aco_regs aco_regs_inst (
	.mclk_i(mclk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i), .wr_en_i(wr_en_i),
	.addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
	.ch_a_input_kind_o(ch_a_input_kind_o), .ch_a_input_source_o(ch_a_input_source_o),
	.ch_a_pulse_mic_sel_o(ch_a_pulse_mic_sel_o),
	.ch_a_coupling_select_o(ch_a_coupling_select_o), .ch_a_dc_coupled_o(ch_a_dc_coupled_o),
	.ch_a_impedance_select_o(ch_a_impedance_select_o),
	.ch_a_range_enhance_on_o(ch_a_range_enhance_on_o),
	.ch_a_gain_code_o(ch_a_gain_code_o), .ch_a_gain_negative_o(ch_a_gain_negative_o),
	.ch_a_gain_half_db_o(ch_a_gain_half_db_o), .ch_a_gain_invalid_o(ch_a_gain_invalid_o),
	.ch_a_volume_code_o(ch_a_volume_code_o), .ch_a_mute_o(ch_a_mute_o),
	.ch_a_volume_half_db_o(ch_a_volume_half_db_o), .ch_a_gain_trim_o(ch_a_gain_trim_o),
	.ch_a_trim_tenth_db_o(ch_a_trim_tenth_db_o), .ch_a_phase_trim_o(ch_a_phase_trim_o)
);
always #50 mclk_i = ~mclk_i;
task chk(input string n, input [9:0] s, input [9:0] e);
	checked = checked + 1;
	if (s !== e)
	begin
		errors = errors + 1;
		$display("ERROR %s expected %h seen %h", n, e, s);
	end
endtask
task wr(input [7:0] a, input [7:0] d);
	@(posedge mclk_i);
	addr_i <= a;
	wdata_i <= d;
	wr_en_i <= 1'h1;
	@(posedge mclk_i);
	wr_en_i <= 1'h0;
endtask
// rdata lags the address by one edge
task rd(input [7:0] a, input [7:0] e);
	@(posedge mclk_i);
	addr_i <= a;
	@(posedge mclk_i);
	#1 chk("rdata", rdata_o, e);
endtask
// ----------------
// scenarios
// ----------------
task t_reset;
	rd(8'h3c, 8'h00);
	rd(8'h3d, 8'h00);
	rd(8'h3e, 8'hc9);
	rd(8'h3f, 8'h80);
	rd(8'h40, 8'h00);
	chk("vol", ch_a_volume_code_o, 10'h0c9);
	chk("vhalf", ch_a_volume_half_db_o, 10'h000);
	chk("ttenth", ch_a_trim_tenth_db_o, 10'h000);
	chk("gtrim", ch_a_gain_trim_o, 10'h008);
	chk("ghalf", ch_a_gain_half_db_o, 10'h000);
endtask
task t_setup;
	wr(8'h3c, 8'hff);
	rd(8'h3c, 8'hfd);
	chk("inv", ch_a_gain_invalid_o, 10'h001);
	chk("kind", ch_a_input_kind_o, 10'h001);
	chk("enh", ch_a_range_enhance_on_o, 10'h001);
	chk("src", ch_a_input_source_o, 10'h003);
	chk("imp", ch_a_impedance_select_o, 10'h003);
	// pulse source chosen; gpio routing for the microphone is software's job
	wr(8'h3c, 8'h54);
	rd(8'h3c, 8'h54);
	chk("dc", ch_a_dc_coupled_o, 10'h000);
	chk("pulse", ch_a_pulse_mic_sel_o, 10'h001);
	chk("imp", ch_a_impedance_select_o, 10'h001);
	chk("couple", ch_a_coupling_select_o, 10'h001);
	chk("kind", ch_a_input_kind_o, 10'h000);
	wr(8'h3c, 8'h34);
	rd(8'h3c, 8'h34);
	chk("dc", ch_a_dc_coupled_o, 10'h001);
	chk("pulse", ch_a_pulse_mic_sel_o, 10'h000);
	chk("enh", ch_a_range_enhance_on_o, 10'h000);
endtask
task t_gain;
	wr(8'h3d, 8'ha9);
	rd(8'h3d, 8'ha9);
	chk("inv", ch_a_gain_invalid_o, 10'h000);
	chk("gcode", ch_a_gain_code_o, 10'h054);
	chk("gneg", ch_a_gain_negative_o, 10'h001);
	chk("ghalf", ch_a_gain_half_db_o, 10'h054);
	wr(8'h3d, 8'haa);
	rd(8'h3d, 8'haa);
	chk("inv", ch_a_gain_invalid_o, 10'h001);
	wr(8'h3d, 8'h03);
	wr(8'h3c, 8'h00);
	rd(8'h3c, 8'h00);
	chk("inv", ch_a_gain_invalid_o, 10'h001);
endtask
task t_vol_trim;
	wr(8'h3e, 8'h00);
	rd(8'h3e, 8'h00);
	chk("mute", ch_a_mute_o, 10'h001);
	chk("vhalf", ch_a_volume_half_db_o, 10'h337);
	wr(8'h3e, 8'hff);
	rd(8'h3e, 8'hff);
	chk("mute", ch_a_mute_o, 10'h000);
	chk("vhalf", ch_a_volume_half_db_o, 10'h036);
	wr(8'h3f, 8'hff);
	rd(8'h3f, 8'hf0);
	chk("trim", ch_a_gain_trim_o, 10'h00f);
	chk("ttenth", ch_a_trim_tenth_db_o, 10'h007);
	wr(8'h3f, 8'h0f);
	rd(8'h3f, 8'h00);
	chk("ttenth", ch_a_trim_tenth_db_o, 10'h3f8);
endtask
// a write with the enable low must leave the register alone
task t_misc;
	wr(8'h40, 8'hff);
	rd(8'h40, 8'hff);
	chk("phase", ch_a_phase_trim_o, 10'h0ff);
	wr(8'h41, 8'h55);
	rd(8'h41, 8'h00);
	@(posedge mclk_i);
	clk_en_i <= 1'h0;
	wr(8'h40, 8'h12);
	clk_en_i <= 1'h1;
	rd(8'h40, 8'hff);
	chk("phase", ch_a_phase_trim_o, 10'h0ff);
endtask
task end_of_test;
	$display("errors %0d checked %0d", errors, checked);
	if (errors == 0 && checked > 0)
		$display("[ PASS ]");
	else
		$display("[ FAIL ]");
	$finish;
endtask
initial
begin
	repeat (12) @(posedge mclk_i);
	reset_n_i <= 1'h1;
	t_reset;
	t_setup;
	t_gain;
	t_vol_trim;
	t_misc;
	end_of_test;
end
initial
begin
	repeat (600) @(posedge mclk_i);
	errors = errors + 1;
	end_of_test;
end
endmodule
